// ---- isf_pkg.sv ----
package isf_pkg;

  // APB register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_TXBUF = 8'h04;
  localparam logic [7:0] OFF_RXBUF = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0c;
  localparam logic [7:0] OFF_MASK = 8'h10;

  // Status bit positions
  localparam int unsigned B_ACK = 15;
  localparam int unsigned B_TR = 14;
  localparam int unsigned B_ACK_WINDOW_FLAG = 13;
  localparam int unsigned B_BCL = 10;
  localparam int unsigned B_GC = 9;
  localparam int unsigned B_TEN_BIT_ADDR_MATCHED = 8;
  localparam int unsigned B_TX_WRITE_COLLISION = 7;
  localparam int unsigned B_OV = 6;
  localparam int unsigned B_STOP = 4;
  localparam int unsigned B_START = 3;
  localparam int unsigned B_RBF = 1;

  // Status geometry and masks
  localparam int unsigned ST_W = 16;
  localparam logic [15:0] ST_IMPL = 16'he7da;
  localparam logic [15:0] ST_W1C = 16'h24d8;
  localparam logic [15:0] ST_RESET = 16'h0000;

  // Control field positions
  localparam int unsigned C_MASTER = 0;
  localparam int unsigned C_GC_EN = 1;
  localparam int unsigned C_A10_EN = 2;
  localparam int unsigned C_ADDR_LO = 16;
  localparam int unsigned C_ADDR_HI = 25;

  // Bit counting along a byte
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_LAST_DATA = 4'h7;
  localparam logic [3:0] CNT_BYTE = 4'h8;
  localparam logic [3:0] CNT_ACK = 4'h9;

  // Address constants
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;

  // Control register image
  typedef struct packed {
    logic [9:0] own_addr;
    logic addr10_en;
    logic gc_en;
    logic master_mode;
  } isf_ctrl_t;

  // Synchronised bus events
  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;
  } isf_bus_ev_t;

  // Frame phase seen by the address matcher
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ADDR = 2'b01,
    PH_ADDR_LO = 2'b10,
    PH_DATA = 2'b11
  } isf_phase_t;

endpackage

// ---- isf_pin_sync.sv ----
`timescale 1ns/1ps
module isf_pin_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output isf_pkg::isf_bus_ev_t ev
);

  // First stage, read only by the second
  logic scl_m_q;
  logic sda_m_q;
  // Second stage, safe to use
  logic scl_s_q;
  logic sda_s_q;
  // Previous safe value for edge finding
  logic scl_p_q;
  logic sda_p_q;

  // Two-flop synchronisers; idle bus is high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_m_q <= 1'b1;
      sda_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else if (ce) begin
      scl_m_q <= scl_in;
      sda_m_q <= sda_in;
      scl_s_q <= scl_m_q;
      sda_s_q <= sda_m_q;
    end
  end

  // History stage for edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (ce) begin
      scl_p_q <= scl_s_q;
      sda_p_q <= sda_s_q;
    end
  end

  // SDA moving while SCL stays high marks start or stop
  always_comb begin
    ev.start = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
    ev.stop = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
    ev.scl_rise = scl_s_q && !scl_p_q;
    ev.scl_fall = !scl_s_q && scl_p_q;
    ev.sda = sda_s_q;
  end

endmodule

// ---- isf_sticky.sv ----
`timescale 1ns/1ps
module isf_sticky #(
  parameter int unsigned W = 16,
  parameter logic [W-1:0] IMPL = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] q
);

  // One flag per bit; unimplemented bits stay zero
  for (genvar i = 0; i < W; i++) begin : g_bit
    if (IMPL[i]) begin : g_impl
      // Set beats clear so a same-cycle event survives
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          q[i] <= 1'b0;
        end else if (ce) begin
          if (set[i]) begin // [R12]
            q[i] <= 1'b1;
          end else if (clr[i]) begin
            q[i] <= 1'b0;
          end
        end
      end
    end else begin : g_none
      assign q[i] = 1'b0;
    end
  end

endmodule

// ---- isf_status_flags.sv ----
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
// Summary of operation
// [R1] NACK sets, ACK clears result at ack end
// [R2] Busy flag high during 8 bits plus ACK
// [R3] Busy set on master transmit buffer write, cleared at ack end
// [R4] Slave: ack window set on 8th fall
// [R5] Slave: ack window cleared on 9th rise
// [R6] Master collision sets collision flag
// [R7] General call sets flag, stop clears it
// [R8] Ten-bit second byte match sets flag
// [R9] Busy transmit write rejected, collision flagged
// [R10] Byte into full receive buffer flags overflow
// [R11] Status bits 31-16, 12-11 read zero
// [R12] Hardware set beats software clear
module isf_status_flags (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic [7:0] tx_data,
  output logic tx_load,
  output logic irq
);

  // Synchronised bus events
  isf_pkg::isf_bus_ev_t ev;
  // Status flags and their drivers
  logic [15:0] st;
  logic [15:0] st_set;
  logic [15:0] st_clr;
  // Software registers
  isf_pkg::isf_ctrl_t ctrl_q;
  logic [15:0] mask_q;
  logic [7:0] rx_buf_q;
  logic [7:0] tx_buf_q;
  logic [7:0] tx_shift_q;
  logic tx_load_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  // Bit tracking on the bus
  logic [3:0] bit_cnt_q;
  logic [7:0] rx_shift_q;
  logic ack_smp_q;
  logic rw_q;
  isf_pkg::isf_phase_t phase_q;
  // Decoded events
  logic fall8;
  logic rise9;
  logic fall9;
  logic slave;
  logic acc;
  logic wr;
  logic rd;
  logic tx_wr;
  logic tx_busy;
  logic collide;
  logic a7_hit;
  logic gc_hit;
  logic a10_hi_hit;
  logic a10_lo_hit;
  logic rx_byte;
  logic mapped;

  // Pin synchronisers and edge finder
  isf_pin_sync u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ev(ev)
  );

  // Status flags, one sticky cell each
  isf_sticky #(
    .W(isf_pkg::ST_W),
    .IMPL(isf_pkg::ST_IMPL)
  ) u_flags (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .set(st_set),
    .clr(st_clr),
    .q(st)
  );

  // APB decode; zero wait states
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // Offsets this slave answers
  always_comb begin
    unique case (paddr)
      isf_pkg::OFF_STATUS, isf_pkg::OFF_TXBUF, isf_pkg::OFF_RXBUF,
      isf_pkg::OFF_CTRL, isf_pkg::OFF_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Mode and bus edges worth naming
  assign slave = !ctrl_q.master_mode;
  assign fall8 = ev.scl_fall && (bit_cnt_q == isf_pkg::CNT_BYTE);
  assign rise9 = ev.scl_rise && (bit_cnt_q == isf_pkg::CNT_BYTE);
  assign fall9 = ev.scl_fall && (bit_cnt_q == isf_pkg::CNT_ACK);

  // Transmit buffer writes and the busy window
  assign tx_busy = st[isf_pkg::B_TR];
  assign tx_wr = wr && (paddr == isf_pkg::OFF_TXBUF);

  // Released one while the line reads low: we lost
  assign collide = tx_busy && ev.scl_rise && (bit_cnt_q < isf_pkg::CNT_BYTE) &&
                   tx_shift_q[7] && !ev.sda;

  // Address comparisons on the completed byte
  assign a7_hit = !ctrl_q.addr10_en && (rx_shift_q[7:1] == ctrl_q.own_addr[6:0]);
  assign gc_hit = ctrl_q.gc_en && (rx_shift_q == isf_pkg::GC_ADDR);
  assign a10_hi_hit = ctrl_q.addr10_en &&
                      (rx_shift_q[7:3] == isf_pkg::TEN_BIT_PREFIX) &&
                      (rx_shift_q[2:1] == ctrl_q.own_addr[9:8]);
  assign a10_lo_hit = rx_shift_q == ctrl_q.own_addr[7:0];

  // A data byte written to us is complete
  assign rx_byte = slave && fall8 && (phase_q == isf_pkg::PH_DATA) && !rw_q;

  // Sets and clears of every status flag
  always_comb begin
    st_set = '0;
    st_clr = '0;
    // Software write-one-to-clear on clearable bits
    if (wr && (paddr == isf_pkg::OFF_STATUS)) begin
      st_clr = pwdata[15:0] & isf_pkg::ST_W1C;
    end
    // Acknowledge result written at end of master transmit ack
    if (tx_busy && fall9) begin
      st_set[isf_pkg::B_ACK] = ack_smp_q; // [R1]
      st_clr[isf_pkg::B_ACK] = !ack_smp_q; // [R1]
    end
    // Transmit in progress spans data and ack
    if (tx_wr && !tx_busy && ctrl_q.master_mode) begin
      st_set[isf_pkg::B_TR] = 1'b1; // [R3]
    end
    if (tx_busy && (fall9 || collide)) begin
      st_clr[isf_pkg::B_TR] = 1'b1; // [R2]
    end
    // Ack window, slave only
    if (slave && fall8 && (phase_q != isf_pkg::PH_IDLE)) begin
      st_set[isf_pkg::B_ACK_WINDOW_FLAG] = 1'b1; // [R4]
    end
    if (rise9) begin
      st_clr[isf_pkg::B_ACK_WINDOW_FLAG] = 1'b1; // [R5]
    end
    // Arbitration loss
    if (collide) begin
      st_set[isf_pkg::B_BCL] = 1'b1; // [R6]
    end
    // Address results held until stop
    if (slave && fall8 && (phase_q == isf_pkg::PH_ADDR) && gc_hit) begin
      st_set[isf_pkg::B_GC] = 1'b1; // [R7]
    end
    if (slave && fall8 && (phase_q == isf_pkg::PH_ADDR_LO) && a10_lo_hit) begin
      st_set[isf_pkg::B_TEN_BIT_ADDR_MATCHED] = 1'b1; // [R8]
    end
    if (ev.stop) begin
      st_clr[isf_pkg::B_GC] = 1'b1; // [R7]
      st_clr[isf_pkg::B_TEN_BIT_ADDR_MATCHED] = 1'b1; // [R8]
    end
    // Rejected write into a busy transmit buffer
    if (tx_wr && tx_busy) begin
      st_set[isf_pkg::B_TX_WRITE_COLLISION] = 1'b1; // [R9]
    end
    // Receive buffer full or overflow
    if (rx_byte && st[isf_pkg::B_RBF]) begin
      st_set[isf_pkg::B_OV] = 1'b1; // [R10]
    end
    if (rx_byte) begin
      st_set[isf_pkg::B_RBF] = 1'b1;
    end
    if (rd && (paddr == isf_pkg::OFF_RXBUF)) begin
      st_clr[isf_pkg::B_RBF] = 1'b1;
    end
    // Start and stop indicators exclude each other
    if (ev.start) begin
      st_set[isf_pkg::B_START] = 1'b1;
      st_clr[isf_pkg::B_STOP] = 1'b1;
    end
    if (ev.stop) begin
      st_set[isf_pkg::B_STOP] = 1'b1;
      st_clr[isf_pkg::B_START] = 1'b1;
    end
  end

  // Control register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= '0;
    end else if (ce && wr && (paddr == isf_pkg::OFF_CTRL)) begin
      ctrl_q.master_mode <= pwdata[isf_pkg::C_MASTER];
      ctrl_q.gc_en <= pwdata[isf_pkg::C_GC_EN];
      ctrl_q.addr10_en <= pwdata[isf_pkg::C_A10_EN];
      ctrl_q.own_addr <= pwdata[isf_pkg::C_ADDR_HI:isf_pkg::C_ADDR_LO];
    end
  end

  // Interrupt mask, same layout as status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_q <= '0;
    end else if (ce && wr && (paddr == isf_pkg::OFF_MASK)) begin
      mask_q <= pwdata[15:0] & isf_pkg::ST_IMPL;
    end
  end

  // Level interrupt from any enabled flag
  assign irq = |(st & mask_q);

  // Transmit buffer; busy writes never land
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_buf_q <= '0;
      tx_load_q <= 1'b0;
    end else if (ce) begin
      tx_load_q <= 1'b0;
      if (tx_wr && !tx_busy) begin // [R9]
        tx_buf_q <= pwdata[7:0];
        tx_load_q <= 1'b1;
      end
    end
  end

  assign tx_data = tx_buf_q;
  assign tx_load = tx_load_q;

  // Copy of the byte on the wire, msb is current bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_shift_q <= '0;
    end else if (ce) begin
      if (tx_wr && !tx_busy) begin
        tx_shift_q <= pwdata[7:0];
      end else if (tx_busy && ev.scl_fall && (bit_cnt_q >= isf_pkg::CNT_ONE) &&
                   (bit_cnt_q <= isf_pkg::CNT_LAST_DATA)) begin
        // Next bit goes out while SCL is low
        tx_shift_q <= {tx_shift_q[6:0], 1'b0};
      end
    end
  end

  // Bit counter: rises counted, cleared after ack
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_cnt_q <= isf_pkg::CNT_ZERO;
    end else if (ce) begin
      if (ev.start || ev.stop) begin
        bit_cnt_q <= isf_pkg::CNT_ZERO;
      end else if (ev.scl_rise && (bit_cnt_q < isf_pkg::CNT_ACK)) begin
        bit_cnt_q <= bit_cnt_q + isf_pkg::CNT_ONE;
      end else if (fall9) begin
        bit_cnt_q <= isf_pkg::CNT_ZERO;
      end
    end
  end

  // Receive shift register samples on SCL rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_shift_q <= '0;
    end else if (ce && ev.scl_rise && (bit_cnt_q < isf_pkg::CNT_BYTE)) begin
      rx_shift_q <= {rx_shift_q[6:0], ev.sda};
    end
  end

  // Ack level seen on the ninth rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_smp_q <= 1'b0;
    end else if (ce && rise9) begin
      ack_smp_q <= ev.sda; // [R1]
    end
  end

  // Receive buffer keeps the old byte on overflow
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_buf_q <= '0;
    end else if (ce && rx_byte && !st[isf_pkg::B_RBF]) begin
      rx_buf_q <= rx_shift_q;
    end
  end

  // Address phase tracking for slave matching
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q <= isf_pkg::PH_IDLE;
      rw_q <= 1'b0;
    end else if (ce) begin
      if (ev.stop) begin
        phase_q <= isf_pkg::PH_IDLE;
      end else if (ev.start) begin
        // Repeated start also reopens addressing
        phase_q <= isf_pkg::PH_ADDR;
      end else if (fall8) begin
        unique case (phase_q)
          isf_pkg::PH_ADDR: begin
            rw_q <= rx_shift_q[0];
            if (a10_hi_hit && !rx_shift_q[0]) begin
              phase_q <= isf_pkg::PH_ADDR_LO;
            end else if (a7_hit || gc_hit) begin
              phase_q <= isf_pkg::PH_DATA;
            end else begin
              // Not for us: sit out until the next start
              phase_q <= isf_pkg::PH_IDLE;
            end
          end
          isf_pkg::PH_ADDR_LO: begin
            phase_q <= a10_lo_hit ? isf_pkg::PH_DATA : isf_pkg::PH_IDLE;
          end
          isf_pkg::PH_DATA: begin
            phase_q <= isf_pkg::PH_DATA;
          end
          isf_pkg::PH_IDLE: begin
            phase_q <= isf_pkg::PH_IDLE;
          end
        endcase
      end
    end
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (ce && psel && !penable) begin
      pslverr_q <= !mapped;
      prdata_q <= '0;
      unique case (paddr)
        isf_pkg::OFF_STATUS: prdata_q <= {16'h0000, st}; // [R11]
        isf_pkg::OFF_TXBUF: prdata_q <= {24'h000000, tx_buf_q};
        isf_pkg::OFF_RXBUF: prdata_q <= {24'h000000, rx_buf_q};
        isf_pkg::OFF_CTRL: begin
          prdata_q[isf_pkg::C_MASTER] <= ctrl_q.master_mode;
          prdata_q[isf_pkg::C_GC_EN] <= ctrl_q.gc_en;
          prdata_q[isf_pkg::C_A10_EN] <= ctrl_q.addr10_en;
          prdata_q[isf_pkg::C_ADDR_HI:isf_pkg::C_ADDR_LO] <= ctrl_q.own_addr;
        end
        isf_pkg::OFF_MASK: prdata_q <= {16'h0000, mask_q};
        default: prdata_q <= '0;
      endcase
    end
  end

endmodule

// ---- isf_bus_agent.sv ----
`timescale 1ns/1ps
// Other bus agent: a master on SCL/SDA, 80 ns link clock
module isf_bus_agent (
  output logic scl,
  output logic sda
);
  // Both lines pulled up; SCL stands still between frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // SDA falls while SCL high
  task automatic start_c();
    #3;
    sda = 1'b0;
    #40;
    scl = 1'b0;
  endtask
  // Data only changes while SCL is low
  task automatic bit_c(input logic v);
    sda = v;
    #20;
    scl = 1'b1;
    #40;
    scl = 1'b0;
    #20;
  endtask
  // Most significant bit first
  task automatic byte_c(input logic [7:0] b);
    #3;
    for (int i = 7; i >= 0; i--) bit_c(b[i]);
  endtask
  // SDA rises while SCL high, then the line is released
  task automatic stop_c();
    #3;
    sda = 1'b0;
    #20;
    scl = 1'b1;
    #20;
    sda = 1'b1;
    #40;
  endtask
endmodule

// ---- isf_status_flags_chk.sv ----
`timescale 1ns/1ps
// Port-level checks of the status block
module isf_status_flags_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [7:0] tx_data,
  input wire logic tx_load,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic acc;
  logic mapped;
  logic mask_off_q;
  // Completed access phase
  assign acc = psel && penable && pready;
  assign mapped = paddr inside {isf_pkg::OFF_STATUS, isf_pkg::OFF_TXBUF, isf_pkg::OFF_RXBUF,
    isf_pkg::OFF_CTRL, isf_pkg::OFF_MASK};
  // Tracks a mask known to be all zero; unknown until written
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_off_q <= 1'b0;
    end else if (acc && pwrite && paddr == isf_pkg::OFF_MASK) begin
      mask_off_q <= (pwdata[15:0] == 16'h0000);
    end
  end
  a_status_zero_hi: assert property (
    acc && !pwrite && paddr == isf_pkg::OFF_STATUS |-> prdata[31:16] == 16'h0000
    && prdata[12:11] == 2'b00) else $error("status reserved bits not zero");
  a_load_cause: assert property (
    $rose(tx_load) |-> $past(acc && pwrite && paddr == isf_pkg::OFF_TXBUF))
    else $error("transmit load without buffer write");
  // A frozen block holds its pulse, so only a running cycle must end it
  a_load_pulse: assert property (
    tx_load && ce |=> !tx_load) else $error("load longer than one cycle");
  // Clock enable low keeps prdata, tx_data, tx_load and irq where they were
  a_freeze_hold: assert property (
    !ce |=> $stable(prdata) && $stable(tx_data) && $stable(tx_load) && $stable(irq))
    else $error("state moved while frozen");
  a_load_data: assert property (
    tx_load |-> tx_data == $past(pwdata[7:0])) else $error("loaded byte differs");
  a_ready_always: assert property (pready == 1'b1) else $error("ready low");
  a_bad_addr_err: assert property (
    acc && !mapped |-> pslverr && prdata == 32'h0000_0000) else $error("unmapped not refused");
  a_good_addr_ok: assert property (acc && mapped |-> !pslverr) else $error("mapped access refused");
  a_txbuf_mirror: assert property (
    acc && !pwrite && paddr == isf_pkg::OFF_TXBUF |-> prdata == {24'h000000, tx_data})
    else $error("transmit buffer readback differs");
  a_mask_quiet: assert property (mask_off_q |-> !irq) else $error("irq while mask zero");
  c_tx_write: cover property (acc && pwrite && paddr == isf_pkg::OFF_TXBUF);
  c_irq: cover property (irq);
  c_refused: cover property (acc && pslverr);
  c_frozen: cover property (!ce && acc);
endmodule
bind isf_status_flags isf_status_flags_chk isf_status_flags_chk_i (.clk(clk), .rst(rst),
  .ce(ce), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .sda_in(sda_in),
  .tx_data(tx_data), .tx_load(tx_load), .irq(irq));

// ---- isf_status_flags_tb.sv ----
`timescale 1ns/1ps
module isf_status_flags_tb;
  localparam logic [7:0] ST = isf_pkg::OFF_STATUS;
  localparam logic [7:0] TX = isf_pkg::OFF_TXBUF;
  localparam logic [7:0] MK = isf_pkg::OFF_MASK;
  // Start, stop and receive-full bits are not judged here
  localparam logic [31:0] DC = 32'hffff_ffe5;
  logic clk, rst, ce, psel, penable, pwrite, pready, pslverr, tx_load, irq, scl, sda;
  logic [7:0] paddr, tx_data, b0, b1;
  logic [31:0] pwdata, prdata;
  logic [63:0] exp_q[$];
  logic [63:0] mon_e;
  logic [9:0] own;
  int n_fail, check_count;
  isf_status_flags isf_status_flags_i (.clk(clk), .rst(rst), .ce(ce), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda), .tx_data(tx_data),
    .tx_load(tx_load), .irq(irq));
  isf_bus_agent isf_bus_agent_i (.scl(scl), .sda(sda));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Let the edge's updates land before looking
  task automatic chk_irq(input logic e);
    #1;
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  // One APB transfer; waits on pready with a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      results();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Notes the expected word, then reads
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({m, e});
    apb(1'b0, a, 32'h0);
  endtask
  // Read monitor: oldest note against the data taken at the access edge
  always @(posedge clk) begin
    if (!rst && psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) begin
        chk("read without note", 32'h0, 32'h1);
      end else begin
        mon_e = exp_q.pop_front();
        chk("read data", mon_e[31:0], prdata & mon_e[63:32]);
      end
    end
  end
  // Hang guard
  initial begin
    #800_000;
    n_fail++;
    results();
  end
  initial begin
    ce = 1'b1;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_fail = 0;
    check_count = 0;
    void'($urandom(22));
    own = 10'($urandom) & 10'h3bf;
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(ST, 32'h0, 32'hffff_ffff);
    rd(8'h20, 32'h0, 32'hffff_ffff);
    // Master transmit: second write while busy must bounce
    apb(1'b1, isf_pkg::OFF_CTRL, 32'h1);
    apb(1'b1, TX, {24'h0, b0});
    apb(1'b1, TX, {24'h0, ~b0});
    rd(ST, 32'h4080, DC);
    rd(TX, {24'h0, b0}, 32'hffff_ffff);
    isf_bus_agent_i.start_c();
    isf_bus_agent_i.byte_c(b0);
    isf_bus_agent_i.bit_c(1'b1);
    rd(ST, 32'h8080, DC);
    apb(1'b1, ST, 32'h80);
    apb(1'b1, TX, {24'h0, b1});
    rd(ST, 32'hc000, DC);
    isf_bus_agent_i.byte_c(b1);
    isf_bus_agent_i.bit_c(1'b0);
    rd(ST, 32'h0, DC);
    // Sent one seen as zero: lost arbitration
    apb(1'b1, TX, {24'h0, b1 | 8'h80});
    // Pins move off the clock edge, never on it
    #3;
    isf_bus_agent_i.bit_c(1'b0);
    rd(ST, 32'h0400, DC);
    isf_bus_agent_i.stop_c();
    apb(1'b1, ST, 32'h400);
    // Slave with general call and ten-bit matching
    apb(1'b1, isf_pkg::OFF_CTRL, {6'h0, own, 13'h0, 3'b110});
    isf_bus_agent_i.start_c();
    isf_bus_agent_i.byte_c(8'h00);
    rd(ST, 32'h2200, DC);
    #3;
    isf_bus_agent_i.bit_c(1'b0);
    rd(ST, 32'h0200, DC);
    isf_bus_agent_i.stop_c();
    rd(ST, 32'h0, DC);
    isf_bus_agent_i.start_c();
    isf_bus_agent_i.byte_c({5'h1e, own[9:8], 1'b0});
    isf_bus_agent_i.bit_c(1'b0);
    isf_bus_agent_i.byte_c(own[7:0]);
    rd(ST, 32'h2100, DC);
    #3;
    isf_bus_agent_i.bit_c(1'b0);
    // Two bytes with no buffer read between: overflow
    isf_bus_agent_i.byte_c(b0);
    isf_bus_agent_i.bit_c(1'b0);
    isf_bus_agent_i.byte_c(b1);
    isf_bus_agent_i.bit_c(1'b0);
    rd(ST, 32'h0140, DC);
    rd(isf_pkg::OFF_RXBUF, {24'h0, b0}, 32'hffff_ffff);
    isf_bus_agent_i.stop_c();
    rd(ST, 32'h0040, DC);
    // Interrupt: masked, unmasked, cleared
    apb(1'b1, MK, 32'h0);
    chk_irq(1'b0);
    apb(1'b1, MK, 32'h40);
    chk_irq(1'b1);
    apb(1'b1, ST, 32'h40);
    chk_irq(1'b0);
    rd(ST, 32'h0, DC);
    // Clock enable low: a transmit write must not land
    ce <= 1'b0;
    apb(1'b1, TX, {24'h0, ~b1});
    ce <= 1'b1;
    rd(TX, {24'h0, b1 | 8'h80}, 32'hffff_ffff);
    repeat (4) @(posedge clk);
    results();
  end
endmodule
